// ==== hw/kwu_wake.sv ====
// Purpose: Key wakeup logic that ends and guards the STOP standby mode
// Assumes: AHB-Lite slave with zero wait states, one clock i_clock
// Notes: Pins are synchronised, so release reacts about three clocks late
`timescale 1ns/1ps
`default_nettype none

module kwu_wake #(
  parameter int WARM_CYCLES = kwu_pkg::WARM_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  input wire logic i_stop_pin,
  input wire logic [3:0] i_key_wake,
  output logic o_stop_mode,
  output logic o_warmup,
  output logic o_release,
  output logic o_irq
);
  localparam int CW = $clog2(WARM_CYCLES + 1);
  localparam logic [CW-1:0] WARM_LAST = CW'(WARM_CYCLES - 1);

  // Two-stage synchronisers
  logic [3:0] key_s1;
  logic [3:0] key_s2;
  logic main_s1;
  logic main_s2;
  logic main_prev;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      key_s1 <= 4'hf;
      key_s2 <= 4'hf;
      main_s1 <= 1'b0;
      main_s2 <= 1'b0;
      main_prev <= 1'b0;
    end else begin
      key_s1 <= i_key_wake;
      key_s2 <= key_s1;
      main_s1 <= i_stop_pin;
      main_s2 <= main_s1;
      main_prev <= main_s2;
    end
  end

  // Bus address phase
  logic a_valid;
  logic a_hit;
  logic [13:0] a_idx;

  assign a_valid = i_hsel & i_htrans[1] & i_hready;
  assign a_idx = i_haddr[15:2];
  assign a_hit = (i_haddr[31:16] == kwu_pkg::ADDR_HIGH);

  logic dp_write;
  logic [13:0] dp_idx;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      dp_write <= 1'b0;
      dp_idx <= 14'h0000;
    end else begin
      dp_write <= a_valid & a_hit & i_hwrite;
      dp_idx <= a_idx;
    end
  end

  logic wr_en;
  logic wr_mask;
  logic wr_ctrl;

  assign wr_en = dp_write & (dp_idx == kwu_pkg::IDX_WAKE_EN);
  assign wr_mask = dp_write & (dp_idx == kwu_pkg::IDX_MASK);
  assign wr_ctrl = dp_write & (dp_idx == kwu_pkg::IDX_CTRL);

  logic rd_any;
  assign rd_any = a_valid & a_hit & ~i_hwrite;

  // Configuration registers
  logic [3:0] wake_en;
  logic level_mode;
  logic [kwu_pkg::NUM_EV-1:0] mask;
  logic stop_cmd;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      wake_en <= kwu_pkg::EN_RESET;
    end else if (wr_en) begin
      wake_en <= i_hwdata[kwu_pkg::EN_MSB:kwu_pkg::EN_LSB];
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      level_mode <= kwu_pkg::CTRL_LEVEL_RESET;
    end else if (wr_ctrl) begin
      level_mode <= i_hwdata[kwu_pkg::CTRL_LEVEL_BIT];
    end
  end

  // Next mask also feeds o_irq, so a mask write acts on the interrupt at once
  logic [kwu_pkg::NUM_EV-1:0] next_mask;
  assign next_mask = wr_mask ? i_hwdata[kwu_pkg::NUM_EV-1:0] : mask;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      mask <= kwu_pkg::EV_NONE;
    end else if (wr_mask) begin
      mask <= next_mask;
    end
  end

  assign stop_cmd = wr_ctrl & i_hwdata[kwu_pkg::CTRL_STOP_BIT];

  // Release request: pure logic of pins and enables, no state of its own
  logic key_req;
  logic main_req;
  logic release_req;
  logic entry_block;

  assign key_req = |(wake_en & ~key_s2);
  assign main_req = level_mode ? main_s2 : (main_s2 & ~main_prev);
  assign release_req = main_req | key_req;
  // Edge mode also refuses on a high level, not only a fresh edge
  assign entry_block = main_s2 | key_req;

  // Standby sequencer
  kwu_pkg::kwu_state_t state;
  kwu_pkg::kwu_state_t next_state;
  logic [kwu_pkg::NUM_EV-1:0] events;
  logic [CW-1:0] warm_cnt;

  always_comb begin
    next_state = state;
    events = kwu_pkg::EV_NONE;
    unique case (state)
      kwu_pkg::KWU_RUN: begin
        if (stop_cmd && entry_block) begin
          next_state = kwu_pkg::KWU_WARM;
          events[kwu_pkg::EV_REFUSED] = 1'b1;
        end else if (stop_cmd) begin
          next_state = kwu_pkg::KWU_STOP;
        end
      end
      kwu_pkg::KWU_STOP: begin
        if (release_req) begin
          next_state = kwu_pkg::KWU_WARM;
          events[kwu_pkg::EV_RELEASED] = 1'b1;
        end
      end
      kwu_pkg::KWU_WARM: begin
        if (warm_cnt == WARM_LAST) begin
          next_state = kwu_pkg::KWU_RUN;
          events[kwu_pkg::EV_WARM_DONE] = 1'b1;
        end
      end
      default: begin
        next_state = kwu_pkg::KWU_RUN;
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state <= kwu_pkg::KWU_RUN;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      warm_cnt <= '0;
    end else if (state == kwu_pkg::KWU_WARM) begin
      warm_cnt <= warm_cnt + 1'b1;
    end else begin
      warm_cnt <= '0;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_stop_mode <= 1'b0;
      o_warmup <= 1'b0;
      o_release <= 1'b0;
    end else begin
      o_stop_mode <= (next_state == kwu_pkg::KWU_STOP);
      o_warmup <= (next_state == kwu_pkg::KWU_WARM);
      o_release <= events[kwu_pkg::EV_RELEASED];
    end
  end

  // Sticky status; a new event beats the read clear
  logic [kwu_pkg::NUM_EV-1:0] status;
  logic [kwu_pkg::NUM_EV-1:0] next_status;
  logic rd_status;

  assign rd_status = rd_any & (a_idx == kwu_pkg::IDX_STATUS);

  always_comb begin
    next_status = rd_status ? kwu_pkg::EV_NONE : status;
    next_status = next_status | events;
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      status <= kwu_pkg::EV_NONE;
      o_irq <= 1'b0;
    end else begin
      status <= next_status;
      o_irq <= |(next_status & next_mask);
    end
  end

  // Read data loaded at the address phase edge, zero wait states
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = kwu_pkg::RD_ZERO;
    if (rd_any) begin
      unique case (a_idx)
        kwu_pkg::IDX_STATUS: next_rdata[kwu_pkg::NUM_EV-1:0] = status;
        kwu_pkg::IDX_MASK: next_rdata[kwu_pkg::NUM_EV-1:0] = mask;
        kwu_pkg::IDX_CTRL: next_rdata[kwu_pkg::CTRL_LEVEL_BIT] = level_mode;
        kwu_pkg::IDX_PORT: begin
          next_rdata[3:0] = key_s2;
          next_rdata[kwu_pkg::PORT_MAIN_BIT] = main_s2;
        end
        // Enable register is write-only and reads as zero
        default: next_rdata = kwu_pkg::RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_hrdata <= kwu_pkg::RD_ZERO;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else begin
      o_hrdata <= next_rdata;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  a_pin_reaches_release: assert property (
    (state == kwu_pkg::KWU_STOP && wake_en[0] && !i_key_wake[0]) [*3]
    |=> state != kwu_pkg::KWU_STOP)
    else $error("Enabled key pin held low did not end STOP");

  a_enable_bits_write: assert property (
    wr_en |=> wake_en == $past(i_hwdata[kwu_pkg::EN_MSB:kwu_pkg::EN_LSB]))
    else $error("Enable bits not taken from data bits 7 to 4");

  a_enable_reads_zero: assert property (
    rd_any && a_idx == kwu_pkg::IDX_WAKE_EN |=> o_hrdata == 32'h0000_0000)
    else $error("Write-only enable register read non-zero");

  a_key_low_release: assert property (
    state == kwu_pkg::KWU_STOP && |(wake_en & ~key_s2)
    |=> state == kwu_pkg::KWU_WARM ##0 o_warmup)
    else $error("Enabled key low did not start warm-up");

  a_level_release: assert property (
    state == kwu_pkg::KWU_STOP && level_mode && main_s2
    |=> state == kwu_pkg::KWU_WARM)
    else $error("Main pin high did not release in level mode");

  a_edge_needs_rise: assert property (
    state == kwu_pkg::KWU_STOP && !level_mode && main_prev && key_req == 1'b0
    |=> state == kwu_pkg::KWU_STOP)
    else $error("Steady high main pin released in edge mode");

  a_refuse_entry: assert property (
    state == kwu_pkg::KWU_RUN && stop_cmd && (main_s2 || key_req)
    |=> state == kwu_pkg::KWU_WARM && status[kwu_pkg::EV_REFUSED])
    else $error("Pending release did not refuse STOP entry");

  a_port_levels: assert property (
    rd_any && a_idx == kwu_pkg::IDX_PORT |=> o_hrdata[3:0] == $past(key_s2))
    else $error("Port read does not show key pin levels");

  a_no_request_stays: assert property (
    state == kwu_pkg::KWU_STOP && !release_req |=> state == kwu_pkg::KWU_STOP)
    else $error("STOP left without a release request");

  a_irq_tracks: assert property (
    o_irq == |(status & mask))
    else $error("Interrupt output disagrees with masked status");

  a_edge_release: assert property (
    state == kwu_pkg::KWU_STOP && !level_mode && main_s2 && !main_prev
    |=> state == kwu_pkg::KWU_WARM && o_release)
    else $error("Rising main pin did not release in edge mode");

  a_warm_holds: assert property (
    state == kwu_pkg::KWU_WARM && warm_cnt != WARM_LAST |=> state == kwu_pkg::KWU_WARM && o_warmup)
    else $error("Warm-up ended before its count");

  a_warm_ends: assert property (
    state == kwu_pkg::KWU_WARM && warm_cnt == WARM_LAST
    |=> state == kwu_pkg::KWU_RUN && !o_warmup && status[kwu_pkg::EV_WARM_DONE])
    else $error("Warm-up did not end with its status bit");

  a_release_pulse: assert property (
    o_release |=> !o_release)
    else $error("Release pulse longer than one cycle");

  a_bus_okay: assert property (
    o_hreadyout && !o_hresp)
    else $error("Bus slave inserted a wait state or an error");

  a_status_sticky: assert property (
    !rd_status |=> (status & $past(status)) == $past(status))
    else $error("Status bit lost without a status read");

endmodule

`default_nettype wire

// ==== pkg/kwu_pkg.sv ====
// Purpose: Shared constants and types of the key wakeup STOP release block
// Assumes: AHB-Lite word registers; byte address is four times the index
// Notes: Indices are word indices, not byte addresses
package kwu_pkg;
  localparam logic [13:0] IDX_WAKE_EN = 14'h0f9a;
  localparam logic [13:0] IDX_STATUS = 14'h0f9b;
  localparam logic [13:0] IDX_MASK = 14'h0f9c;
  localparam logic [13:0] IDX_CTRL = 14'h0f9d;
  localparam logic [13:0] IDX_PORT = 14'h0f9e;
  localparam logic [15:0] ADDR_HIGH = 16'h0000;

  localparam int EN_LSB = 4;
  localparam int EN_MSB = 7;
  localparam logic [3:0] EN_RESET = 4'h0;

  localparam int CTRL_LEVEL_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  localparam logic CTRL_LEVEL_RESET = 1'b1;

  localparam int EV_REFUSED = 0;
  localparam int EV_RELEASED = 1;
  localparam int EV_WARM_DONE = 2;
  localparam int NUM_EV = 3;
  localparam logic [2:0] EV_NONE = 3'h0;

  localparam int PORT_MAIN_BIT = 4;

  localparam int CLK_NS = 100;
  localparam int WARM_NS = 1600;
  localparam int WARM_CYCLES = (WARM_NS + CLK_NS - 1) / CLK_NS;

  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    KWU_RUN,
    KWU_STOP,
    KWU_WARM
  } kwu_state_t;
endpackage

// ==== test/key_wakeup_stop_release_tb.sv ====
// Purpose: Self-checking bench of the key wakeup block
// Assumes: Zero wait state bus, warm-up cut to 8 cycles
// Notes: A pin change reaches the state three edges later
`timescale 1ns/1ps
`default_nettype none
module key_wakeup_stop_release_tb;
  typedef struct packed {logic [3:0] en, kin, kst; logic st, wk;} kwu_row_t;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hready, hresp, stop_pin, stop_mode, warmup, rel, irq;
  logic main_req = 1'b0;
  logic [3:0] key_req = 4'hf;
  logic [3:0] key_wake;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  int rels = 0;
  int r0;
  kwu_row_t rows [7] = '{{4'h1, 4'hf, 4'he, 1'b1, 1'b1}, {4'h8, 4'hf, 4'h7, 1'b1, 1'b1},
    {4'h2, 4'hf, 4'hd, 1'b1, 1'b1}, {4'h4, 4'hf, 4'hb, 1'b1, 1'b1}, {4'h6, 4'hf, 4'h6, 1'b1, 1'b0},
    {4'h4, 4'hb, 4'hf, 1'b0, 1'b0}, {4'h0, 4'h0, 4'h0, 1'b1, 1'b0}};
  always #50 i_clock = ~i_clock;
  kwu_wake #(.WARM_CYCLES(8)) DUT (.i_clock(i_clock), .i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
    .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata), .i_stop_pin(stop_pin),
    .i_key_wake(key_wake), .o_stop_mode(stop_mode), .o_warmup(warmup), .o_release(rel), .o_irq(irq));
  kwu_keys u_keys (.i_clock(i_clock), .i_main_req(main_req), .i_key_req(key_req),
    .o_stop_pin(stop_pin), .o_key_wake(key_wake));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  task automatic xfer(input logic [13:0] idx, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {kwu_pkg::ADDR_HIGH, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge i_clock); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge i_clock); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 60 && (warmup !== 1'b0 || stop_mode !== 1'b0); i++) @(posedge i_clock);
  endtask
  task automatic wrap_up;
    $display("compares %0d bad %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge i_clock) begin
    cyc++;
    if (rel === 1'b1) rels++;
    if (cyc == 20000) begin
      bad_count++;
      wrap_up();
    end
  end
  initial begin
    ticks(4);
    chk({hready, hresp, stop_mode, warmup, rel, irq}, 6'h20, "reset outputs");
    i_rst <= 1'b0;
    xfer(kwu_pkg::IDX_CTRL, 1'b0, 0);
    chk(rd, 32'h1, "control reset");
    xfer(kwu_pkg::IDX_STATUS, 1'b0, 0);
    chk(rd, 32'h0, "status reset");
    // Rows: enable, keys at entry, keys in STOP, entered, woken by key
    for (int i = 0; i < 7; i++) begin
      key_req <= rows[i].kin;
      main_req <= 1'b0;
      xfer(kwu_pkg::IDX_WAKE_EN, 1'b1, {24'h0, rows[i].en, 4'h0});
      ticks(3);
      r0 = rels;
      xfer(kwu_pkg::IDX_CTRL, 1'b1, 32'h3);
      ticks(1);
      chk({stop_mode, warmup}, {rows[i].st, !rows[i].st}, "entry");
      if (rows[i].st) begin
        key_req <= rows[i].kst;
        ticks(5);
        chk(warmup, rows[i].wk, "key wake");
        main_req <= 1'b1;
      end
      wait_idle();
      chk(rels - r0, rows[i].st, "release pulse");
      chk(irq, 0, "masked irq");
      xfer(kwu_pkg::IDX_STATUS, 1'b0, 0);
      chk(rd, {29'h0, 1'b1, rows[i].st, !rows[i].st}, "status");
      $display("row %0d done", i);
    end
    xfer(kwu_pkg::IDX_WAKE_EN, 1'b0, 0);
    chk(rd, 32'h0, "enable reads zero");
    xfer(14'h0f99, 1'b0, 0);
    chk(rd, 32'h0, "unmapped read");
    key_req <= 4'ha;
    ticks(4);
    xfer(kwu_pkg::IDX_PORT, 1'b0, 0);
    chk(rd, 32'h1a, "port levels");
    xfer(kwu_pkg::IDX_MASK, 1'b1, 32'h7);
    xfer(kwu_pkg::IDX_MASK, 1'b0, 0);
    chk(rd, 32'h7, "mask readback");
    $display("register test done");
    // Edge mode with keys off, main low before entry
    key_req <= 4'hf;
    main_req <= 1'b0;
    xfer(kwu_pkg::IDX_WAKE_EN, 1'b1, 0);
    xfer(kwu_pkg::IDX_MASK, 1'b1, 32'h2);
    ticks(3);
    xfer(kwu_pkg::IDX_CTRL, 1'b1, 32'h2);
    ticks(1);
    chk(stop_mode, 1, "edge mode entry");
    main_req <= 1'b1;
    ticks(6);
    chk({warmup, irq}, 2'b11, "rising edge wake");
    wait_idle();
    xfer(kwu_pkg::IDX_STATUS, 1'b0, 0);
    chk(rd, 32'h6, "edge status");
    ticks(2);
    chk(irq, 0, "irq cleared by read");
    $display("edge and irq test done");
    // Main still high: edge mode refuses entry too, then a late mask raises irq
    xfer(kwu_pkg::IDX_CTRL, 1'b1, 32'h2);
    xfer(kwu_pkg::IDX_MASK, 1'b1, 32'h1);
    ticks(1);
    chk({stop_mode, warmup, irq}, 3'b011, "refused in edge mode");
    i_rst <= 1'b1;
    ticks(2);
    chk({stop_mode, warmup, irq}, 0, "mid-run reset");
    i_rst <= 1'b0;
    xfer(kwu_pkg::IDX_MASK, 1'b0, 0);
    chk(rd, 32'h0, "mask after reset");
    xfer(kwu_pkg::IDX_CTRL, 1'b0, 0);
    chk(rd, 32'h1, "control after reset");
    xfer(kwu_pkg::IDX_STATUS, 1'b0, 0);
    chk(rd, 32'h0, "status after reset");
    $display("reset test done");
    wrap_up();
  end
endmodule
`default_nettype wire

// ==== test/kwu_keys.sv ====
// Purpose: Keys and main switch on the wake pins
// Assumes: Pins change just after a rising edge
// Notes: Keys idle high through pull-ups
`timescale 1ns/1ps
`default_nettype none
module kwu_keys (
  input wire logic i_clock,
  input wire logic i_main_req,
  input wire logic [3:0] i_key_req,
  output logic o_stop_pin,
  output logic [3:0] o_key_wake
);
  initial begin
    o_stop_pin = 1'b0;
    o_key_wake = 4'hf;
  end
  // Main held low for key wake, keys off or high in edge mode
  // Pins stay plain digital inputs
  always @(posedge i_clock) begin
    o_stop_pin <= i_main_req;
    o_key_wake <= i_key_req;
  end
endmodule
`default_nettype wire
